// ==== rtl/dsw_status.sv ====
// device fault status words: two read-only 16-bit registers
`timescale 1ns/1ps

// Functional notes
// - primary fault word at offset 0000, 1=fault
// - bit 0 set on any memory fault
// - bit 1 flags unit arrangement error
// - bit 3 flags external RAM fault operating
// - bit 4 ORs all programless error flags
// - bit 4 never sets internal comm flag
// - bit 6 flags programless link fault
// - detail word 0001, bits 4,6,9,12
module dsw_status
	import dsw_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  arst_n_i,
	// register port
	input  wire logic [DSW_ADDR_W-1:0] addr_i,
	input  wire logic [DSW_DATA_W-1:0] wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic      [DSW_DATA_W-1:0] rdata_o,
	// memory fault sources, asynchronous levels
	input  wire logic                  nvm_fault_i,
	input  wire logic                  setval_fault_i,
	input  wire logic                  model_data_fault_i,
	input  wire logic                  model_mismatch_fault_i,
	// other fault sources, asynchronous levels
	input  wire logic                  unit_cfg_fault_i,
	input  wire logic                  ext_ram_fault_i,
	input  wire logic                  operating_i,
	input  wire logic                  link_fault_i,
	input  wire logic                  int_comm_fault_i,
	input  wire logic [DSW_PL_N-1:0]   pl_err_i,
	// status views for the rest of the controller
	output logic      [DSW_DATA_W-1:0] primary_word_o,
	output logic      [DSW_DATA_W-1:0] detail_word_o,
	output logic                       int_comm_status_o,
	output logic                       fault_any_o
);

	// address match, used by the read path and the write filter
	function automatic logic dsw_hit(
		input logic [DSW_ADDR_W-1:0] a,
		input logic [DSW_ADDR_W-1:0] off
	);
		dsw_hit = (a == off);
	endfunction : dsw_hit

	dsw_flt_if   flt ();
	dsw_core_st_t st_q;
	dsw_core_st_t st_d;

	// every fault input crosses two flops before any logic sees it
	assign flt.raw[DSW_IX_NVM]  = nvm_fault_i;
	assign flt.raw[DSW_IX_SETV] = setval_fault_i;
	assign flt.raw[DSW_IX_MINF] = model_data_fault_i;
	assign flt.raw[DSW_IX_MMIS] = model_mismatch_fault_i;
	assign flt.raw[DSW_IX_CFG]  = unit_cfg_fault_i;
	assign flt.raw[DSW_IX_XRAM] = ext_ram_fault_i;
	assign flt.raw[DSW_IX_OPER] = operating_i;
	assign flt.raw[DSW_IX_LINK] = link_fault_i;
	assign flt.raw[DSW_IX_ICS]  = int_comm_fault_i;
	assign flt.raw[DSW_IX_PL0 +: DSW_PL_N] = pl_err_i;

	// synchroniser bank
	dsw_sync u_sync
	(
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.flt      (flt.sync_mp)
	);

	// clean copies of the synchronised levels
	logic [DSW_PL_N-1:0] pl_s;
	logic                xram_s;
	logic                oper_s;
	logic                write_seen;

	assign pl_s   = flt.synced[DSW_IX_PL0 +: DSW_PL_N];
	assign xram_s = flt.synced[DSW_IX_XRAM];
	assign oper_s = flt.synced[DSW_IX_OPER];

	// writes land nowhere; decoded only to show they are dropped
	assign write_seen = wr_i &
		(dsw_hit(addr_i, DSW_OFF_PRIMARY) |
		 dsw_hit(addr_i, DSW_OFF_DETAIL));

	// words are rebuilt every cycle from live levels, so a fault
	// bit clears three edges after its source drops; nothing is sticky
	always_comb
	begin
		st_d = st_q;

		// detail word, unused bits held at zero
		st_d.detail = DSW_RST_WORD;
		st_d.detail[DSW_DET_NVM]  = flt.synced[DSW_IX_NVM];
		st_d.detail[DSW_DET_SETV] = flt.synced[DSW_IX_SETV];
		st_d.detail[DSW_DET_MINF] = flt.synced[DSW_IX_MINF];
		st_d.detail[DSW_DET_MMIS] = flt.synced[DSW_IX_MMIS];

		// primary word, unused bits held at zero
		st_d.primary = DSW_RST_WORD;
		// summary taken from the same levels as the detail word, so
		// both words agree in the same cycle
		st_d.primary[DSW_PRI_MEM] =
			flt.synced[DSW_IX_NVM]  | flt.synced[DSW_IX_SETV] |
			flt.synced[DSW_IX_MINF] | flt.synced[DSW_IX_MMIS];
		st_d.primary[DSW_PRI_CFG]  = flt.synced[DSW_IX_CFG];
		// a RAM fault outside operation is not reported here
		st_d.primary[DSW_PRI_XRAM] = xram_s & oper_s;
		st_d.primary[DSW_PRI_ICOM] = |pl_s;
		st_d.primary[DSW_PRI_LINK] = flt.synced[DSW_IX_LINK];

		// internal comm flag follows its own source only
		st_d.ics = flt.synced[DSW_IX_ICS];

		st_d.any = |st_q.primary;

		// read data stand only in the cycle after the strobe;
		// a write or an unmapped address leaves zero
		st_d.rdata = DSW_RST_WORD;
		if (rd_i)
		begin
			if (dsw_hit(addr_i, DSW_OFF_PRIMARY))
			begin
				st_d.rdata = st_q.primary;
			end
			else if (dsw_hit(addr_i, DSW_OFF_DETAIL))
			begin
				st_d.rdata = st_q.detail;
			end
			else
			begin
				st_d.rdata = DSW_RST_WORD;
			end
		end
		// write_seen deliberately changes no state
		if (write_seen)
		begin
			st_d.primary = st_d.primary;
		end
	end

	// constants only under reset
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_q.primary <= DSW_RST_WORD;
			st_q.detail  <= DSW_RST_WORD;
			st_q.ics     <= DSW_RST_BIT;
			st_q.any     <= DSW_RST_BIT;
			st_q.rdata   <= DSW_RST_WORD;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// outputs straight from flops
	assign rdata_o           = st_q.rdata;
	assign primary_word_o    = st_q.primary;
	assign detail_word_o     = st_q.detail;
	assign int_comm_status_o = st_q.ics;
	assign fault_any_o       = st_q.any;

	// write data is never stored
	logic unused_wdata;
	assign unused_wdata = ^wdata_i;

endmodule : dsw_status

// ==== include/dsw_pkg.sv ====
// constants and types for the device fault status words
package dsw_pkg;

	// register port widths
	localparam int unsigned DSW_ADDR_W = 16;
	localparam int unsigned DSW_DATA_W = 16;

	// register offsets, one 16-bit word each
	localparam logic [15:0] DSW_OFF_PRIMARY = 16'h0000;
	localparam logic [15:0] DSW_OFF_DETAIL  = 16'h0001;

	// primary fault word bit positions
	localparam int unsigned DSW_PRI_MEM  = 0;
	localparam int unsigned DSW_PRI_CFG  = 1;
	localparam int unsigned DSW_PRI_XRAM = 3;
	localparam int unsigned DSW_PRI_ICOM = 4;
	localparam int unsigned DSW_PRI_LINK = 6;

	// memory fault detail word bit positions
	localparam int unsigned DSW_DET_NVM  = 4;
	localparam int unsigned DSW_DET_SETV = 6;
	localparam int unsigned DSW_DET_MINF = 9;
	localparam int unsigned DSW_DET_MMIS = 12;

	// values after reset
	localparam logic [15:0] DSW_RST_WORD = 16'h0000;
	localparam logic        DSW_RST_BIT  = 1'b0;

	// number of programless-communication error flags summarised
	localparam int unsigned DSW_PL_N = 8;

	// index of each fault source in the synchronised fault vector
	localparam int unsigned DSW_IX_NVM  = 0;
	localparam int unsigned DSW_IX_SETV = 1;
	localparam int unsigned DSW_IX_MINF = 2;
	localparam int unsigned DSW_IX_MMIS = 3;
	localparam int unsigned DSW_IX_CFG  = 4;
	localparam int unsigned DSW_IX_XRAM = 5;
	localparam int unsigned DSW_IX_OPER = 6;
	localparam int unsigned DSW_IX_LINK = 7;
	localparam int unsigned DSW_IX_ICS  = 8;
	localparam int unsigned DSW_IX_PL0  = 9;
	localparam int unsigned DSW_FLT_N   = DSW_IX_PL0 + DSW_PL_N;

	// synchroniser state: two flip-flops per fault source
	typedef struct packed {
		logic [DSW_FLT_N-1:0] stage1;
		logic [DSW_FLT_N-1:0] stage2;
	} dsw_sync_st_t;

	// register bank state
	typedef struct packed {
		logic [DSW_DATA_W-1:0] primary;
		logic [DSW_DATA_W-1:0] detail;
		logic                  ics;
		logic                  any;
		logic [DSW_DATA_W-1:0] rdata;
	} dsw_core_st_t;

endpackage : dsw_pkg

// ==== include/dsw_flt_if.sv ====
// carrier for raw and synchronised fault levels between modules
`timescale 1ns/1ps
interface dsw_flt_if;
	import dsw_pkg::*;

	logic [DSW_FLT_N-1:0] raw;
	logic [DSW_FLT_N-1:0] synced;

	// the synchroniser takes raw levels and returns clean ones
	modport sync_mp
	(
		input  raw,
		output synced
	);

	// the register bank hands over raw levels, reads clean ones
	modport core_mp
	(
		output raw,
		input  synced
	);
endinterface : dsw_flt_if

// ==== rtl/dsw_sync.sv ====
// two-flop synchroniser bank for the fault source levels
`timescale 1ns/1ps
module dsw_sync
	import dsw_pkg::*;
(
	// clock and reset
	input  wire logic   clk_i,
	input  wire logic   arst_n_i,
	// fault levels in and out
	dsw_flt_if.sync_mp  flt
);

	dsw_sync_st_t st_q;
	dsw_sync_st_t st_d;

	// first stage feeds only the second stage, never logic
	always_comb
	begin
		st_d        = st_q;
		st_d.stage1 = flt.raw;
		st_d.stage2 = st_q.stage1;
	end

	// constants only under reset
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign flt.synced = st_q.stage2;

endmodule : dsw_sync

// ==== bench/dsw_status_props.sv ====
// assertion checker for the device fault status words
`timescale 1ns/1ps
module dsw_status_props
	import dsw_pkg::*;
(
	// clock and reset
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	// register port
	input wire logic [15:0] addr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	// fault sources
	input wire logic        nvm_fault_i,
	input wire logic        setval_fault_i,
	input wire logic        model_data_fault_i,
	input wire logic        model_mismatch_fault_i,
	input wire logic        unit_cfg_fault_i,
	input wire logic        ext_ram_fault_i,
	input wire logic        operating_i,
	input wire logic        link_fault_i,
	input wire logic        int_comm_fault_i,
	input wire logic [7:0]  pl_err_i,
	// status views
	input wire logic [15:0] primary_word_o,
	input wire logic [15:0] detail_word_o,
	input wire logic        int_comm_status_o,
	input wire logic        fault_any_o
);
	logic [1:0]  up_q;
	logic        s_mem;
	logic        s_xram;
	logic        s_pl;
	logic        s_idle;
	logic [15:0] det_e;

	// three edges of history needed before the sync pipe is trusted
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i)
			up_q <= 2'h0;
		else if (up_q != 2'h3)
			up_q <= up_q + 2'h1;

	// source summaries for the delayed comparisons
	assign s_mem = nvm_fault_i | setval_fault_i | model_data_fault_i
		| model_mismatch_fault_i;
	assign s_xram = ext_ram_fault_i & operating_i;
	assign s_pl = |pl_err_i;
	assign s_idle = !rd_i || addr_i > DSW_OFF_DETAIL;
	assign det_e = {3'h0, model_mismatch_fault_i, 2'h0, model_data_fault_i,
		2'h0, setval_fault_i, 1'b0, nvm_fault_i, 4'h0};

	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	// one-cycle read of each mapped word
	sequence rd_pri_s;
		rd_i && addr_i == DSW_OFF_PRIMARY;
	endsequence
	sequence rd_det_s;
		rd_i && addr_i == DSW_OFF_DETAIL;
	endsequence

	mem_sum_a: assert property
		(up_q == 2'h3 |-> primary_word_o[0] == $past(s_mem, 3))
		else $error("memory summary bit wrong");
	cfg_bit_a: assert property
		(up_q == 2'h3 |-> primary_word_o[1] == $past(unit_cfg_fault_i, 3))
		else $error("configuration bit wrong");
	xram_bit_a: assert property
		(up_q == 2'h3 |-> primary_word_o[3] == $past(s_xram, 3))
		else $error("external ram bit wrong");
	pl_sum_a: assert property
		(up_q == 2'h3 |-> primary_word_o[4] == $past(s_pl, 3))
		else $error("programless summary bit wrong");
	ics_own_a: assert property
		(up_q == 2'h3 |-> int_comm_status_o == $past(int_comm_fault_i, 3))
		else $error("internal comm flag wrong");
	link_bit_a: assert property
		(up_q == 2'h3 |-> primary_word_o[6] == $past(link_fault_i, 3))
		else $error("link bit wrong");
	detail_word_a: assert property
		(up_q == 2'h3 |-> detail_word_o == $past(det_e, 3))
		else $error("detail word wrong");
	unused_zero_a: assert property
		((primary_word_o & 16'hFFA4) == 16'h0000)
		else $error("unused primary bit set");
	rd_primary_a: assert property
		(rd_pri_s |=> rdata_o == $past(primary_word_o))
		else $error("primary read wrong");
	rd_detail_a: assert property
		(rd_det_s |=> rdata_o == $past(detail_word_o))
		else $error("detail read wrong");
	rd_idle_a: assert property
		(s_idle |=> rdata_o == 16'h0000)
		else $error("read data not zero");
	det_unused_a: assert property
		((detail_word_o & 16'hEDAF) == 16'h0000)
		else $error("unused detail bit set");
	any_flag_a: assert property
		(up_q == 2'h3 |-> fault_any_o == |$past(primary_word_o))
		else $error("fault summary flag wrong");
endmodule : dsw_status_props

bind dsw_status dsw_status_props u_props (.*);

// ==== bench/dsw_status_tb_top.sv ====
// random and corner-case bench for the fault status words
`timescale 1ns/1ps
module dsw_status_tb_top
	import dsw_pkg::*;
;
	logic        clk_i, arst_n_i, wr_i, rd_i, ics, fa;
	logic [15:0] addr_i, wdata_i, rdata_o, pw, dw, got;
	logic [16:0] f;
	int          n_errors, total_checks;

	dsw_status u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.nvm_fault_i(f[0]), .setval_fault_i(f[1]), .model_data_fault_i(f[2]),
		.model_mismatch_fault_i(f[3]), .unit_cfg_fault_i(f[4]),
		.ext_ram_fault_i(f[5]), .operating_i(f[6]), .link_fault_i(f[7]),
		.int_comm_fault_i(f[8]), .pl_err_i(f[16:9]), .primary_word_o(pw),
		.detail_word_o(dw), .int_comm_status_o(ics), .fault_any_o(fa));

	// 200 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// expected words from the packed fault vector
	function automatic logic [15:0] ep(logic [16:0] v);
		ep = 16'h0000;
		ep[0] = |v[3:0];
		ep[1] = v[4];
		ep[3] = v[5] & v[6];
		ep[4] = |v[16:9];
		ep[6] = v[7];
	endfunction : ep
	function automatic logic [15:0] ed(logic [16:0] v);
		ed = {3'h0, v[3], 2'h0, v[2], 2'h0, v[1], 1'b0, v[0], 4'h0};
	endfunction : ed

	task chk(input string n, input logic [15:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// one-cycle read strobe, data taken in the following cycle
	task rd(input logic [15:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 got = rdata_o;
	endtask : rd

	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	initial
	begin
		{arst_n_i, wr_i, rd_i} = 3'b000;
		{addr_i, wdata_i} = 32'h0000_0000;
		f = 17'h00000;
		n_errors = 0;
		total_checks = 0;
		void'($urandom(32'hA2D3));
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd(DSW_OFF_PRIMARY);
		chk("reset word", got, 16'h0000);
		// first three passes are corners: all set, ram idle, one programless error flag
		for (int i = 0; i < 40; i++)
		begin
			@(posedge clk_i);
			f <= i == 0 ? 17'h1FFFF : i == 1 ? 17'h00020
				: i == 2 ? 17'h10000 : 17'($urandom);
			wr_i <= 1'b1;
			wdata_i <= 16'($urandom);
			addr_i <= 16'(i % 2);
			@(posedge clk_i);
			wr_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			#1;
			chk("primary out", pw, ep(f));
			chk("detail out", dw, ed(f));
			chk("int comm", {15'h0000, ics}, {15'h0000, f[8]});
			// summary flag trails the primary word by one edge
			chk("fault any", {15'h0000, fa}, {15'h0000, |ep(f)});
			rd(DSW_OFF_PRIMARY);
			chk("primary read", got, ep(f));
			rd(DSW_OFF_DETAIL);
			chk("detail read", got, ed(f));
			rd(16'($urandom_range(65535, 2)));
			chk("unmapped read", got, 16'h0000);
		end
		@(posedge clk_i);
		#1;
		chk("idle read data", rdata_o, 16'h0000);
		$display("random test done");
		// second reset in mid-run with faults still present
		@(posedge clk_i);
		arst_n_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk("reset clears", pw, 16'h0000);
		@(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		#1;
		chk("after reset", pw, ep(f));
		$display("reset test done");
		end_of_test();
	end
endmodule : dsw_status_tb_top
